// ### hdl/crc_bit_shifter.sv
// serial shifter and accumulator, one data bit per clock
`timescale 1ns/10ps
`default_nettype none

module crc_bit_shifter #(
   parameter int DATA_W = 16,
   parameter int ACC_W = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // steering
   input wire crc_shift_control_pkg::shift_cfg_type cfg_i,
   input wire logic [ACC_W-1:0] poly_i,
   // load from the data-holding path
   input wire logic load_i,
   input wire logic [DATA_W-1:0] load_data_i,
   // direct accumulator write
   input wire logic acc_wr_i,
   input wire logic [ACC_W-1:0] acc_wdata_i,
   // state
   output logic [ACC_W-1:0] acc_o,
   output logic empty_o
);

   localparam int CNT_W = $clog2(DATA_W + 1);

   // a 16-bit data path is what the holding registers can feed
   generate
      if (DATA_W < 1 || DATA_W > 16 || ACC_W < 2) begin : g_bad_width
         $error("crc_bit_shifter: unsupported width");
      end
   endgenerate

   crc_shift_control_pkg::shift_state_type state_r, state_nxt;
   logic [DATA_W-1:0] shreg_r, shreg_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic step;
   logic data_bit;
   logic feedback;

   // ************************************************************
   // next state of shifter and accumulator
   // ************************************************************
   // stopped shifter keeps its bits; a pending word waits for run
   always_comb begin
      state_nxt = state_r;
      shreg_nxt = shreg_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      step = (state_r == crc_shift_control_pkg::st_shift) && cfg_i.run;
      data_bit = cfg_i.dir_right ? shreg_r[0] : shreg_r[DATA_W-1];
      // augmented mode feeds data in at the bottom, plain mode xors it on top
      feedback = cfg_i.augment ? acc_r[ACC_W-1] : (acc_r[ACC_W-1] ^ data_bit);
      unique case (state_r)
         crc_shift_control_pkg::st_idle: begin
            if (load_i) begin
               shreg_nxt = load_data_i;
               cnt_nxt = CNT_W'(DATA_W);
               state_nxt = crc_shift_control_pkg::st_shift;
            end
         end
         crc_shift_control_pkg::st_shift: begin
            if (step) begin
               shreg_nxt = cfg_i.dir_right ? (shreg_r >> 1) : (shreg_r << 1);
               acc_nxt = {acc_r[ACC_W-2:0], cfg_i.augment & data_bit};
               if (feedback) begin
                  acc_nxt = acc_nxt ^ poly_i;
               end
               cnt_nxt = cnt_r - 1'b1;
               if (cnt_r == CNT_W'(1)) begin
                  state_nxt = crc_shift_control_pkg::st_idle;
               end
            end
         end
      endcase
      if (acc_wr_i) begin
         acc_nxt = acc_wdata_i;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= crc_shift_control_pkg::st_idle;
         shreg_r <= '0;
         cnt_r <= '0;
         acc_r <= '0;
      end else begin
         state_r <= state_nxt;
         shreg_r <= shreg_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
      end
   end

   assign acc_o = acc_r;
   assign empty_o = (state_r == crc_shift_control_pkg::st_idle);

   // ************************************************************
   // checks
   // ************************************************************
   AST_DIR_RIGHT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      step && cfg_i.dir_right |=> shreg_r == ($past(shreg_r) >> 1))
      else $error("right shift did not move data toward bit 0");
   AST_DIR_LEFT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      step && !cfg_i.dir_right |=> shreg_r == ($past(shreg_r) << 1))
      else $error("left shift did not move data toward the top bit");

endmodule : crc_bit_shifter

`default_nettype wire

// ### hdl/crc_shift_control.sv
// crc main control register, data-holding path and apb slave
//
// Function
// - setting the start bit (bit 6) runs the shifter on staged data; here it runs only while enable (bit 7) is also set.
// - while start reads zero the shifter stays stopped, accumulator untouched.
// - busy bit (bit 5) is one while shifting is underway or pending.
// - busy clears only once every valid bit reached the accumulator.
// - full bit (bit 0) is set while holding registers hold untransferred data.
// - full clears when holding data moves into the shifter.
// - direction bit (bit 1) one shifts right, zero shifts left.
// - writing the low holding byte loads the path; high byte goes first.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "crc_shift_control_map.svh"

module crc_shift_control #(
   parameter int DATA_W = 16,
   parameter int ACC_W = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // interrupt
   output logic irq_o
);

   // ************************************************************
   // parameter checks
   // ************************************************************
   // holding registers are two bytes and the poly/acc words 16 bits wide
   generate
      if (DATA_W < 1 || DATA_W > 16 || ACC_W < 2 || ACC_W > 16) begin : g_bad_width
         $error("crc_shift_control: unsupported width");
      end
   endgenerate

   // ************************************************************
   // declarations
   // ************************************************************
   crc_shift_control_pkg::ctrl_type ctrl_r, ctrl_nxt;
   crc_shift_control_pkg::shift_cfg_type shift_cfg;
   logic [7:0] dat_high_r, dat_high_nxt;
   logic [7:0] dat_low_r, dat_low_nxt;
   logic full_r, full_nxt;
   logic [ACC_W-1:0] poly_r, poly_nxt;
   logic [1:0] int_stat_r, int_stat_nxt;
   logic [1:0] int_mask_r, int_mask_nxt;
   logic busy_q_r, busy_q_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic setup;
   logic wr_en;
   logic mapped;
   logic wr_ctrl;
   logic wr_low;
   logic acc_wr;
   logic xfer;
   logic busy;
   logic sh_empty;
   logic [ACC_W-1:0] sh_acc;
   logic [15:0] hold_word;
   logic [1:0] int_event;
   logic [7:0] ctrl_view;

   // ************************************************************
   // bus decode
   // ************************************************************
   // zero wait states: every access phase completes at once
   assign setup = psel_i && !penable_i;
   assign wr_en = psel_i && penable_i && pwrite_i && mapped;
   assign wr_ctrl = wr_en && (paddr_i == `OFS_CTRL);
   assign wr_low = wr_en && (paddr_i == `OFS_DAT_LOW);
   assign acc_wr = wr_en && (paddr_i == `OFS_ACC);

   // decode of the mapped words; anything else answers with an error
   always_comb begin
      unique case (paddr_i)
         `OFS_CTRL, `OFS_DAT_HIGH, `OFS_DAT_LOW, `OFS_ACC,
         `OFS_POLY, `OFS_INT_STAT, `OFS_INT_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   // ************************************************************
   // shifter control
   // ************************************************************
   // shifter only runs while the block is enabled and started
   assign shift_cfg.run = ctrl_r.enable && ctrl_r.start;
   assign shift_cfg.dir_right = ctrl_r.dir_right;
   assign shift_cfg.augment = ctrl_r.augment;

   // staged word moves on only into an empty shifter, so no bit is lost
   assign xfer = full_r && sh_empty && ctrl_r.enable && ctrl_r.start;
   assign hold_word = {dat_high_r, dat_low_r};
   assign busy = full_r || !sh_empty;

   // read-back of crc_main_control with live status bits
   always_comb begin
      ctrl_view = `RST_CTRL;
      ctrl_view[`BIT_ENABLE] = ctrl_r.enable;
      ctrl_view[`BIT_START] = ctrl_r.start;
      ctrl_view[`BIT_BUSY] = busy;
      ctrl_view[`BIT_AUGMENT] = ctrl_r.augment;
      ctrl_view[`BIT_DIR] = ctrl_r.dir_right;
      ctrl_view[`BIT_FULL] = full_r;
   end

   // events: shifting finished, holding path drained
   assign int_event[`BIT_INT_DONE] = busy_q_r && !busy;
   assign int_event[`BIT_INT_DRAINED] = xfer;

   // ************************************************************
   // register next values
   // ************************************************************
   always_comb begin
      ctrl_nxt = ctrl_r;
      dat_high_nxt = dat_high_r;
      dat_low_nxt = dat_low_r;
      full_nxt = full_r;
      poly_nxt = poly_r;
      int_stat_nxt = int_stat_r;
      int_mask_nxt = int_mask_r;
      busy_q_nxt = busy;
      prdata_nxt = prdata_r;
      // writable control fields; busy and full ignore writes
      if (wr_ctrl) begin
         ctrl_nxt.enable = pwdata_i[`BIT_ENABLE];
         ctrl_nxt.start = pwdata_i[`BIT_START];
         ctrl_nxt.augment = pwdata_i[`BIT_AUGMENT];
         ctrl_nxt.dir_right = pwdata_i[`BIT_DIR];
      end
      if (wr_en && paddr_i == `OFS_DAT_HIGH) begin
         dat_high_nxt = pwdata_i[7:0];
      end
      // the low byte completes the word, so it marks the path full
      if (wr_low) begin
         dat_low_nxt = pwdata_i[7:0];
      end
      if (xfer) begin
         full_nxt = 1'b0;
      end
      if (wr_low) begin
         full_nxt = 1'b1;
      end
      if (wr_en && paddr_i == `OFS_POLY) begin
         poly_nxt = pwdata_i[ACC_W-1:0];
      end
      if (wr_en && paddr_i == `OFS_INT_MASK) begin
         int_mask_nxt = pwdata_i[1:0];
      end
      // write one clears; a same-cycle event wins over the clear
      if (wr_en && paddr_i == `OFS_INT_STAT) begin
         int_stat_nxt = int_stat_nxt & ~pwdata_i[1:0];
      end
      int_stat_nxt = int_stat_nxt | int_event;
      // read data captured in the setup phase, stable in the access phase
      if (setup) begin
         unique case (paddr_i)
            `OFS_CTRL: prdata_nxt = {24'h000000, ctrl_view};
            `OFS_DAT_HIGH: prdata_nxt = {24'h000000, dat_high_r};
            `OFS_DAT_LOW: prdata_nxt = {24'h000000, dat_low_r};
            `OFS_ACC: prdata_nxt = 32'(sh_acc);
            `OFS_POLY: prdata_nxt = 32'(poly_r);
            `OFS_INT_STAT: prdata_nxt = {30'h0, int_stat_r};
            `OFS_INT_MASK: prdata_nxt = {30'h0, int_mask_r};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r <= '0;
         dat_high_r <= 8'h00;
         dat_low_r <= 8'h00;
         full_r <= 1'b0;
         poly_r <= ACC_W'(`RST_POLY);
         int_stat_r <= `RST_INT;
         int_mask_r <= `RST_INT;
         busy_q_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         dat_high_r <= dat_high_nxt;
         dat_low_r <= dat_low_nxt;
         full_r <= full_nxt;
         poly_r <= poly_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         busy_q_r <= busy_q_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata_o = prdata_r;
   assign irq_o = |(int_stat_r & int_mask_r);

   // ************************************************************
   // serial shifter
   // ************************************************************
   // the data path keeps its low DATA_W bits of the holding word
   crc_bit_shifter #(
      .DATA_W(DATA_W),
      .ACC_W(ACC_W)
   ) u_shifter (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .cfg_i(shift_cfg),
      .poly_i(poly_r),
      .load_i(xfer),
      .load_data_i(hold_word[DATA_W-1:0]),
      .acc_wr_i(acc_wr),
      .acc_wdata_i(pwdata_i[ACC_W-1:0]),
      .acc_o(sh_acc),
      .empty_o(sh_empty)
   );

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   AST_START_LOADS: assert property (
      full_r && sh_empty && ctrl_r.enable && ctrl_r.start && !wr_low
      |=> !full_r && !sh_empty)
      else $error("staged word not moved into the shifter when started");

   AST_STOPPED_HOLDS: assert property (
      !ctrl_r.start && !acc_wr |=> $stable(sh_acc))
      else $error("accumulator changed while the shifter was stopped");

   AST_LOW_WRITE_BUSY: assert property (
      wr_low |=> full_r && ctrl_view[`BIT_BUSY] && ctrl_view[`BIT_FULL])
      else $error("low byte write did not show full and busy");

   AST_BUSY_CLEAR: assert property (
      $fell(ctrl_view[`BIT_BUSY]) |-> $past(shift_cfg.run) && !$past(sh_empty))
      else $error("busy cleared with bits still pending");

   // a paused word is still pending, so busy must not drop while stopped
   AST_SHIFTING_BUSY: assert property (
      !sh_empty && !shift_cfg.run |=> ctrl_view[`BIT_BUSY])
      else $error("busy low while the shifter holds bits");

   AST_FULL_HOLDS: assert property (
      full_r && !(ctrl_r.enable && ctrl_r.start) |=> full_r)
      else $error("full dropped without a transfer");

   AST_FULL_FALL: assert property (
      $fell(full_r) |-> $past(xfer) && !sh_empty)
      else $error("full cleared without moving data into the shifter");

   AST_DISABLED_IDLE: assert property (
      !ctrl_r.enable && !acc_wr ##1 !ctrl_r.enable && !acc_wr
      |-> $stable(sh_acc) && !$fell(full_r))
      else $error("crc logic moved while disabled");

   AST_DONE_EVENT: assert property (
      busy_q_r && !busy |=> int_stat_r[`BIT_INT_DONE])
      else $error("end of shifting not recorded in status");

endmodule : crc_shift_control

`default_nettype wire

// ### inc/crc_shift_control_map.svh
// register offsets, bit positions and reset values of the crc shift control block
`ifndef CRC_SHIFT_CONTROL_MAP_SVH
`define CRC_SHIFT_CONTROL_MAP_SVH

// byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_DAT_HIGH 8'h04
`define OFS_DAT_LOW 8'h08
`define OFS_ACC 8'h0c
`define OFS_POLY 8'h10
`define OFS_INT_STAT 8'h14
`define OFS_INT_MASK 8'h18

// crc_main_control field positions
`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_BUSY 5
`define BIT_AUGMENT 4
`define BIT_DIR 1
`define BIT_FULL 0

// interrupt status and mask field positions
`define BIT_INT_DONE 0
`define BIT_INT_DRAINED 1

// reset values
`define RST_CTRL 8'h00
`define RST_POLY 16'h0000
`define RST_INT 2'h0

`endif

// ### inc/crc_shift_control_pkg.sv
// types shared by the crc shift control block and its serial shifter
`default_nettype none

package crc_shift_control_pkg;

   // software-written control fields of crc_main_control
   typedef struct packed {
      logic enable;
      logic start;
      logic augment;
      logic dir_right;
   } ctrl_type;

   // steering handed to the serial shifter
   typedef struct packed {
      logic run;
      logic dir_right;
      logic augment;
   } shift_cfg_type;

   // shifter sequencing
   typedef enum logic {
      st_idle,
      st_shift
   } shift_state_type;

endpackage : crc_shift_control_pkg

`default_nettype wire

// ### test/crc_shift_control_bench.sv
// self-checking bench for the crc shift control block
`timescale 1ns/10ps
`default_nettype none
`include "crc_shift_control_map.svh"

module crc_shift_control_bench;
   // ****************************************
   // signals and design
   // ****************************************
   logic clk_sys_i;
   logic resetn_i;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rd;
   logic er;
   int err_total;
   int n_compared;
   int cyc;

   crc_shift_control dut (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .paddr_i(paddr),
      .psel_i(psel),
      .penable_i(penable),
      .pwrite_i(pwrite),
      .pwdata_i(pwdata),
      .prdata_o(prdata),
      .pready_o(pready),
      .pslverr_o(pslverr),
      .irq_o(irq)
   );

   // 100 MHz system clock
   initial begin
      clk_sys_i = 1'h0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one apb transfer; request held until pready is sampled high
   task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel <= 1'h1;
      penable <= 1'h0;
      paddr <= a;
      pwrite <= is_wr;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'h1;
      @(posedge clk_sys_i);
      while (pready !== 1'h1) @(posedge clk_sys_i);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check(what, rd, exp);
   endtask : rchk

   // reference crc step loop, worked out independently of the design
   function automatic logic [15:0] crc_model(input logic [15:0] acc, input logic [15:0] poly,
      input logic [15:0] data, input logic right, input logic aug);
      logic d;
      logic fb;
      for (int i = 0; i < 16; i++) begin
         d = right ? data[i] : data[15-i];
         fb = aug ? acc[15] : acc[15] ^ d;
         acc = aug ? {acc[14:0], d} : {acc[14:0], 1'h0};
         if (fb) acc = acc ^ poly;
      end
      return acc;
   endfunction : crc_model

   task results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // ****************************************
   // scenarios
   // ****************************************
   task t_reset();
      rchk("ctrl reset", `OFS_CTRL, 32'h0);
      rchk("poly reset", `OFS_POLY, 32'h0);
      rchk("acc reset", `OFS_ACC, 32'h0);
      rchk("status reset", `OFS_INT_STAT, 32'h0);
      rchk("mask reset", `OFS_INT_MASK, 32'h0);
      check("irq reset", {31'h0, irq}, 32'h0);
      check("ready", {31'h0, pready}, 32'h1);
      rchk("unmapped read", 8'h1c, 32'h0);
      check("unmapped error", {31'h0, er}, 32'h1);
      $display("test reset done");
   endtask : t_reset

   // busy and full are read-only, bits 3:2 read zero, unmapped writes dropped
   task t_regs();
      wr(`OFS_CTRL, 32'hff);
      rchk("ctrl written", `OFS_CTRL, 32'hd2);
      check("mapped error", {31'h0, er}, 32'h0);
      wr(8'h1c, 32'h0);
      check("unmapped write error", {31'h0, er}, 32'h1);
      rchk("ctrl kept", `OFS_CTRL, 32'hd2);
      wr(`OFS_CTRL, 32'h0);
      $display("test regs done");
   endtask : t_regs

   // stage a word, hold it stopped and disabled, then run it through
   task t_run(input logic dir, input logic aug, input logic [15:0] data);
      logic [31:0] mode;
      logic [15:0] expv;
      int n;
      mode = {27'h0, aug, 2'h0, dir, 1'h0};
      expv = crc_model(16'hffff, 16'h1021, data, dir, aug);
      wr(`OFS_POLY, 32'h1021);
      wr(`OFS_ACC, 32'hffff);
      wr(`OFS_CTRL, mode | 32'h80);
      wr(`OFS_DAT_HIGH, {24'h0, data[15:8]});
      rchk("ctrl high only", `OFS_CTRL, mode | 32'h80);
      wr(`OFS_DAT_LOW, {24'h0, data[7:0]});
      rchk("ctrl staged", `OFS_CTRL, mode | 32'ha1);
      repeat (20) @(posedge clk_sys_i);
      rchk("acc stopped", `OFS_ACC, 32'hffff);
      wr(`OFS_CTRL, mode | 32'h40);
      repeat (20) @(posedge clk_sys_i);
      rchk("ctrl disabled", `OFS_CTRL, mode | 32'h61);
      rchk("acc disabled", `OFS_ACC, 32'hffff);
      wr(`OFS_CTRL, mode | 32'hc0);
      rchk("ctrl loaded", `OFS_CTRL, mode | 32'he0);
      n = 0;
      do begin
         apb(1'h0, `OFS_CTRL, 32'h0);
         n++;
      end while (rd[5] !== 1'h0 && n < 30);
      check("ctrl idle", rd, mode | 32'hc0);
      rchk("acc result", `OFS_ACC, {16'h0, expv});
      rchk("status after run", `OFS_INT_STAT, 32'h3);
      wr(`OFS_INT_MASK, 32'h1);
      @(posedge clk_sys_i);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      wr(`OFS_INT_STAT, 32'h1);
      @(posedge clk_sys_i);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rchk("status one left", `OFS_INT_STAT, 32'h2);
      wr(`OFS_INT_STAT, 32'h2);
      wr(`OFS_INT_MASK, 32'h0);
      wr(`OFS_CTRL, 32'h0);
      $display("test run dir %0d aug %0d done", dir, aug);
   endtask : t_run

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      resetn_i = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'h1;
      t_reset();
      t_regs();
      // every direction and augment pairing on a word that reads the same in either bit order
      for (int k = 0; k < 4; k++) begin
         t_run(k[0], k[1], 16'h3a5c);
      end
      results();
   end

   // the whole run needs about 530 cycles; a hang ends it early
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         results();
      end
   end
endmodule : crc_shift_control_bench
`default_nettype wire
